/* File: hw/hlcf_top.v */
/*
  host link control flags: vendor_identifier register, set/clear control flag pair,
  configuration rom gating, late ack handling and a small interrupt bank.
  assumes a one-cycle strobe register port on sys_clk_i; the packet requests
  and bus reset arrive from the phy side as pin levels and are synchronised.
*/
`timescale 1ns/1ps
`include "hlcf_defs.vh"
module hlcf_top #(
  parameter [31:0] VENDOR_IDENTIFIER = 32'h00AB_CDEF // arbitrary value
) (
  input wire sys_clk_i,
  input wire srst_i,
  input wire [7:0] reg_addr_i,
  input wire [31:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  output reg [31:0] reg_rdata_o,
  input wire pkt_req_i,
  input wire pkt_rom_read_i,
  input wire pkt_self_i,
  input wire bus_reset_i,
  input wire fetch_error_i,
  input wire phy_event_i,
  output reg ack_valid_o,
  output reg [3:0] ack_code_o,
  output reg pkt_accept_o,
  output reg rom_update_o,
  output reg byte_swap_o,
  output reg link_active_o,
  output reg irq_o
);
  reg [31:0] ctrl_reg;
  reg [31:0] ctrl_next;
  reg [31:0] irq_status_reg;
  reg [31:0] irq_status_next;
  reg [31:0] irq_mask_reg;
  reg [31:0] rom_map_reg;
  reg [31:0] rom_hdr_reg;
  reg [31:0] bus_opt_reg;
  reg [31:0] rom_map_pend_reg;
  reg [31:0] rom_hdr_pend_reg;
  reg [31:0] bus_opt_pend_reg;
  reg [3:0] srst_cnt_reg;
  reg [4:0] pin_prev_reg;
  reg sent_late_reg;
  wire [4:0] pin_sync;
  wire soft_rst;
  wire req_rise;
  wire bus_reset_rise;
  wire image_valid;
  wire link_en;
  wire late_en;

  // pins from the phy side cross into sys_clk_i
  hlcf_sync2 #(
    .WIDTH(5)
  ) u_sync (
    .sys_clk_i(sys_clk_i),
    .srst_i(srst_i),
    .async_i({phy_event_i, bus_reset_i, pkt_self_i, pkt_rom_read_i, pkt_req_i}),
    .sync_o(pin_sync)
  );

  assign image_valid = ctrl_reg[`HLCF_BIT_IMAGE_VALID];
  assign link_en = ctrl_reg[`HLCF_BIT_LINK_ACTIVE_ENABLE];
  assign late_en = ctrl_reg[`HLCF_BIT_ACK_LATE_ENABLE];
  assign soft_rst = ctrl_reg[`HLCF_BIT_SOFT_RESET];
  assign req_rise = pin_sync[0] & ~pin_prev_reg[0];
  assign bus_reset_rise = pin_sync[3] & ~pin_prev_reg[3];

  // address decode helper, shared by read and write paths
  function hit;
    input [7:0] addr;
    input [7:0] ofs;
    begin
      hit = (addr == ofs);
    end
  endfunction

  // control flags: write one to set or clear, clear wins only by write order
  always @* begin
    ctrl_next = ctrl_reg;
    if (reg_wr_i && hit(reg_addr_i, `HLCF_OFS_CTRL_SET)) begin
      ctrl_next = ctrl_next | (reg_wdata_i & `HLCF_CTRL_WMASK);
    end
    if (reg_wr_i && hit(reg_addr_i, `HLCF_OFS_CTRL_CLR)) begin
      ctrl_next = ctrl_next & ~(reg_wdata_i & `HLCF_CTRL_WMASK);
    end
    if (fetch_error_i) begin
      ctrl_next[`HLCF_BIT_IMAGE_VALID] = 1'b0;
    end
    // 28..24 and other reserved bits stay zero
    ctrl_next = ctrl_next & (`HLCF_CTRL_WMASK | `HLCF_CTRL_RESET);
  end

  // soft reset holds a few cycles, then reloads hardware reset values
  always @(posedge sys_clk_i) begin
    if (srst_i) begin
      ctrl_reg <= `HLCF_CTRL_RESET;
      srst_cnt_reg <= 4'h0;
    end else if (soft_rst) begin
      if (srst_cnt_reg == `HLCF_SOFT_RESET_CYCLES) begin
        ctrl_reg <= `HLCF_CTRL_RESET;
        srst_cnt_reg <= 4'h0;
      end else begin
        srst_cnt_reg <= srst_cnt_reg + 4'h1;
      end
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  // rom mirror registers: pending copies load into live ones on bus reset while image valid is set
  always @(posedge sys_clk_i) begin
    if (srst_i || soft_rst) begin
      rom_map_reg <= 32'h0000_0000;
      rom_hdr_reg <= 32'h0000_0000;
      bus_opt_reg <= 32'h0000_0000;
      rom_map_pend_reg <= 32'h0000_0000;
      rom_hdr_pend_reg <= 32'h0000_0000;
      bus_opt_pend_reg <= 32'h0000_0000;
    end else begin
      if (reg_wr_i && hit(reg_addr_i, `HLCF_OFS_ROM_MAP_PEND)) begin
        rom_map_pend_reg <= {reg_wdata_i[31:10], 10'h000};
      end
      if (reg_wr_i && hit(reg_addr_i, `HLCF_OFS_ROM_HDR_PEND)) begin
        rom_hdr_pend_reg <= reg_wdata_i;
      end
      if (reg_wr_i && hit(reg_addr_i, `HLCF_OFS_BUS_OPT_PEND)) begin
        bus_opt_pend_reg <= reg_wdata_i;
      end
      // invalid image leaves the live copies frozen
      if (bus_reset_rise && image_valid) begin
        rom_map_reg <= rom_map_pend_reg;
        rom_hdr_reg <= rom_hdr_pend_reg;
        bus_opt_reg <= bus_opt_pend_reg;
      end
    end
  end

  // answer one packet per rising request; link off means no answer at all
  always @(posedge sys_clk_i) begin
    if (srst_i || soft_rst) begin
      pin_prev_reg <= 5'h00;
      ack_valid_o <= 1'b0;
      ack_code_o <= 4'h0;
      pkt_accept_o <= 1'b0;
      sent_late_reg <= 1'b0;
    end else begin
      pin_prev_reg <= pin_sync;
      ack_valid_o <= 1'b0;
      pkt_accept_o <= 1'b0;
      sent_late_reg <= 1'b0;
      if (req_rise && link_en) begin
        ack_valid_o <= 1'b1;
        if (late_en) begin
          // own and other async packets alike get the late ack
          ack_code_o <= `HLCF_ACK_TARDY;
          sent_late_reg <= 1'b1;
        end else if (pin_sync[1] && !image_valid) begin
          ack_code_o <= `HLCF_ACK_TYPE_ERROR;
        end else begin
          ack_code_o <= pin_sync[1] ? `HLCF_ACK_COMPLETE : `HLCF_ACK_PENDING;
          pkt_accept_o <= 1'b1;
        end
      end
    end
  end

  // sticky events, set wins over write-one-to-clear
  always @* begin
    irq_status_next = irq_status_reg;
    if (reg_wr_i && hit(reg_addr_i, `HLCF_OFS_IRQ_STATUS)) begin
      irq_status_next = irq_status_next & ~(reg_wdata_i & `HLCF_IRQ_WMASK);
    end
    if (sent_late_reg) begin
      irq_status_next[`HLCF_IRQ_BIT_ACK_LATE] = 1'b1;
    end
    if (pin_sync[4] & ~pin_prev_reg[4]) begin
      irq_status_next[`HLCF_IRQ_BIT_PHY] = 1'b1;
    end
  end

  always @(posedge sys_clk_i) begin
    if (srst_i || soft_rst) begin
      irq_status_reg <= 32'h0000_0000;
      irq_mask_reg <= 32'h0000_0000;
    end else begin
      irq_status_reg <= irq_status_next;
      if (reg_wr_i && hit(reg_addr_i, `HLCF_OFS_IRQ_MASK)) begin
        irq_mask_reg <= reg_wdata_i & `HLCF_IRQ_WMASK;
      end
    end
  end

  // registered status outputs
  always @(posedge sys_clk_i) begin
    if (srst_i) begin
      byte_swap_o <= 1'b0;
      link_active_o <= 1'b0;
      rom_update_o <= 1'b0;
      irq_o <= 1'b0;
    end else begin
      byte_swap_o <= ~ctrl_reg[`HLCF_BIT_BYTE_SWAP_INHIBIT];
      link_active_o <= link_en;
      rom_update_o <= image_valid;
      irq_o <= |(irq_status_next & irq_mask_reg);
    end
  end

  // read data one cycle after the strobe, zero otherwise
  always @(posedge sys_clk_i) begin
    if (srst_i) begin
      reg_rdata_o <= 32'h0000_0000;
    end else if (reg_rd_i) begin
      if (hit(reg_addr_i, `HLCF_OFS_VENDOR_IDENTIFIER)) begin
        reg_rdata_o <= VENDOR_IDENTIFIER;
      end else if (hit(reg_addr_i, `HLCF_OFS_CTRL_SET) || hit(reg_addr_i, `HLCF_OFS_CTRL_CLR)) begin
        reg_rdata_o <= ctrl_reg;
      end else if (hit(reg_addr_i, `HLCF_OFS_IRQ_STATUS)) begin
        reg_rdata_o <= irq_status_reg;
      end else if (hit(reg_addr_i, `HLCF_OFS_IRQ_MASK)) begin
        reg_rdata_o <= irq_mask_reg;
      end else if (hit(reg_addr_i, `HLCF_OFS_ROM_MAP)) begin
        reg_rdata_o <= rom_map_reg;
      end else if (hit(reg_addr_i, `HLCF_OFS_ROM_HDR)) begin
        reg_rdata_o <= rom_hdr_reg;
      end else if (hit(reg_addr_i, `HLCF_OFS_BUS_OPT)) begin
        reg_rdata_o <= bus_opt_reg;
      end else if (hit(reg_addr_i, `HLCF_OFS_ROM_MAP_PEND)) begin
        reg_rdata_o <= rom_map_pend_reg;
      end else if (hit(reg_addr_i, `HLCF_OFS_ROM_HDR_PEND)) begin
        reg_rdata_o <= rom_hdr_pend_reg;
      end else if (hit(reg_addr_i, `HLCF_OFS_BUS_OPT_PEND)) begin
        reg_rdata_o <= bus_opt_pend_reg;
      end else begin
        reg_rdata_o <= 32'h0000_0000; // unmapped reads zero
      end
    end else begin
      reg_rdata_o <= 32'h0000_0000;
    end
  end
endmodule

/* File: include/hlcf_defs.vh */
/*
  register offsets, field positions, reset values and codes for the host link
  control flags block. assumes word-addressed 8-bit byte offsets on the
  register port.
*/
`ifndef HLCF_DEFS_VH
`define HLCF_DEFS_VH

// register byte offsets
`define HLCF_OFS_VENDOR_IDENTIFIER 8'h40
`define HLCF_OFS_CTRL_SET 8'h50
`define HLCF_OFS_CTRL_CLR 8'h54
`define HLCF_OFS_IRQ_STATUS 8'h80
`define HLCF_OFS_IRQ_MASK 8'h88
`define HLCF_OFS_ROM_MAP 8'h34
`define HLCF_OFS_ROM_HDR 8'h18
`define HLCF_OFS_BUS_OPT 8'h20
`define HLCF_OFS_ROM_MAP_PEND 8'hA0
`define HLCF_OFS_ROM_HDR_PEND 8'hA4
`define HLCF_OFS_BUS_OPT_PEND 8'hA8

// control flag positions
`define HLCF_BIT_IMAGE_VALID 31
`define HLCF_BIT_BYTE_SWAP_INHIBIT 30
`define HLCF_BIT_ACK_LATE_ENABLE 29
`define HLCF_BIT_PHY_PROGRAM 23
`define HLCF_BIT_PHY_ENHANCE 22
`define HLCF_BIT_LINK_POWER 19
`define HLCF_BIT_POSTED_WRITE 18
`define HLCF_BIT_LINK_ACTIVE_ENABLE 17
`define HLCF_BIT_SOFT_RESET 16

// writable control bits and reset value
`define HLCF_CTRL_WMASK 32'hE04F_0000
`define HLCF_CTRL_RESET 32'h0080_0000

// interrupt status positions
`define HLCF_IRQ_BIT_PHY 19
`define HLCF_IRQ_BIT_ACK_LATE 27
`define HLCF_IRQ_WMASK 32'h0808_0000

// 1394 ack codes
`define HLCF_ACK_COMPLETE 4'h1
`define HLCF_ACK_PENDING 4'h2
`define HLCF_ACK_TARDY 4'hB
`define HLCF_ACK_TYPE_ERROR 4'hE

// soft reset end count; soft reset lasts this count plus one cycles
`define HLCF_SOFT_RESET_CYCLES 4'h4

`endif

/* File: hw/hlcf_sync2.v */
/*
  two-flop synchroniser for a vector of pin-level inputs.
  assumes the inputs are levels that stay put for several clocks.
*/
`timescale 1ns/1ps
module hlcf_sync2 #(
  parameter WIDTH = 4
) (
  input wire sys_clk_i,
  input wire srst_i,
  input wire [WIDTH-1:0] async_i,
  output reg [WIDTH-1:0] sync_o
);
  reg [WIDTH-1:0] meta_reg;

  // first stage feeds only the second stage
  always @(posedge sys_clk_i) begin
    if (srst_i) begin
      meta_reg <= {WIDTH{1'b0}};
      sync_o <= {WIDTH{1'b0}};
    end else begin
      meta_reg <= async_i;
      sync_o <= meta_reg;
    end
  end
endmodule

/* File: dv/hlcf_props.sv */
/*
  port-level checker for hlcf_top.
  assumes one clock and the synchronous reset srst_i.
*/
`timescale 1ns/1ps
module hlcf_props #(
  parameter [31:0] VENDOR_IDENTIFIER = 32'h0000_0000
) (
  input wire sys_clk_i,
  input wire srst_i,
  input wire [7:0] reg_addr_i,
  input wire [31:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  input wire [31:0] reg_rdata_o,
  input wire pkt_req_i,
  input wire ack_valid_o,
  input wire [3:0] ack_code_o,
  input wire byte_swap_o,
  input wire link_active_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);
  // read port: data only in the cycle after a read
  property p_vid; $past(reg_rd_i) && $past(reg_addr_i) == 8'h40 |-> reg_rdata_o == VENDOR_IDENTIFIER; endproperty
  a_vid: assert property (p_vid) else $error("vendor_identifier read wrong");
  property p_idle; !$past(reg_rd_i) |-> reg_rdata_o == 32'h0000_0000; endproperty
  a_idle: assert property (p_idle) else $error("read data outside read slot");
  property p_rsvd; $past(reg_rd_i) && $past(reg_addr_i[7:3]) == 5'h0A |-> reg_rdata_o[28:24] == 5'h00; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved control bits set");
  // acknowledge side: gated by link, one pulse, caused by a request; then swap inhibit on a set write
  property p_off; !link_active_o |-> !ack_valid_o; endproperty
  a_off: assert property (p_off) else $error("ack while link off");
  property p_pulse; ack_valid_o |=> !ack_valid_o; endproperty
  a_pulse: assert property (p_pulse) else $error("ack longer than one cycle");
  property p_code; ack_valid_o |-> ack_code_o inside {4'h1, 4'h2, 4'hB, 4'hE}; endproperty
  a_code: assert property (p_code) else $error("ack code unknown");
  property p_cause; ack_valid_o |-> $past(pkt_req_i, 2); endproperty
  a_cause: assert property (p_cause) else $error("ack without request");
  property p_swap; reg_wr_i && reg_addr_i == 8'h50 && reg_wdata_i[30] |-> ##[1:2] !byte_swap_o; endproperty
  a_swap: assert property (p_swap) else $error("swap inhibit not applied");
endmodule
bind hlcf_top hlcf_props #(.VENDOR_IDENTIFIER(VENDOR_IDENTIFIER)) u_props (.sys_clk_i(sys_clk_i), .srst_i(srst_i),
  .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .pkt_req_i(pkt_req_i), .ack_valid_o(ack_valid_o), .ack_code_o(ack_code_o),
  .byte_swap_o(byte_swap_o), .link_active_o(link_active_o));

/* File: dv/hlcf_node_model.sv */
/*
  far-side bus node: packet arrivals, bus reset and phy events as pin levels.
  assumes the caller waits for each task to finish.
*/
`timescale 1ns/1ps
module hlcf_node_model (
  input wire clk_i,
  output logic pkt_req_o = 1'b0,
  output logic rom_o = 1'b0,
  output logic self_o = 1'b0,
  output logic bus_reset_o = 1'b0,
  output logic phy_event_o = 1'b0
);
  // one packet; qualifiers scrambled after release so stale values never help
  task pkt(input logic rom);
    @(posedge clk_i);
    rom_o <= rom;
    self_o <= rom;
    pkt_req_o <= 1'b1;
    repeat (4) @(posedge clk_i);
    pkt_req_o <= 1'b0;
    rom_o <= ~rom;
    self_o <= ~rom;
    repeat (3) @(posedge clk_i);
  endtask
  // level pulse long enough for the synchroniser
  task evt(input logic is_phy);
    @(posedge clk_i);
    phy_event_o <= is_phy;
    bus_reset_o <= ~is_phy;
    repeat (4) @(posedge clk_i);
    phy_event_o <= 1'b0;
    bus_reset_o <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask
endmodule

/* File: dv/hlcf_top_tb.sv */
/*
  self-checking bench for hlcf_top.
  assumes hlcf_node_model on the bus side and the register port driven here.
*/
`timescale 1ns/1ps
module hlcf_top_tb;
  localparam logic [31:0] VID = 32'h1357_9BDF; // arbitrary value
  logic clk = 1'b0, srst = 1'b1, wr = 1'b0, rd = 1'b0, fetch = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] ack_last = 4'h0;
  wire [31:0] rdata;
  wire [3:0] code;
  wire req, rom, slf, brst, phy, ackv, acc, romu, swap, link, irq;
  int n_ack = 0, n_acc = 0, n_errors = 0, num_checks = 0, k, j;
  logic [40:0] rows [12] = '{{1'b0, 8'h50, 32'h0080_0000}, {1'b0, 8'h54, 32'h0080_0000},
    {1'b1, 8'h40, 32'hFFFF_FFFF}, {1'b0, 8'h40, VID}, {1'b1, 8'h50, 32'hFF00_0000},
    {1'b0, 8'h54, 32'hE080_0000}, {1'b1, 8'h54, 32'h4000_0000}, {1'b1, 8'h50, 32'h0000_0000},
    {1'b0, 8'h50, 32'hA080_0000}, {1'b0, 8'hFC, 32'h0000_0000}, {1'b1, 8'h88, 32'h0808_0000},
    {1'b0, 8'h88, 32'h0808_0000}};
  hlcf_top #(.VENDOR_IDENTIFIER(VID)) dut (.sys_clk_i(clk), .srst_i(srst), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .pkt_req_i(req), .pkt_rom_read_i(rom),
    .pkt_self_i(slf), .bus_reset_i(brst), .fetch_error_i(fetch), .phy_event_i(phy), .ack_valid_o(ackv),
    .ack_code_o(code), .pkt_accept_o(acc), .rom_update_o(romu), .byte_swap_o(swap),
    .link_active_o(link), .irq_o(irq));
  hlcf_node_model node (.clk_i(clk), .pkt_req_o(req), .rom_o(rom), .self_o(slf), .bus_reset_o(brst),
    .phy_event_o(phy));
  // 40 mhz clock
  initial begin
    forever #12.5 clk = ~clk;
  end
  // acks counted here so a missing or extra pulse shows
  always @(posedge clk) begin
    if (ackv === 1'b1) begin
      n_ack <= n_ack + 1;
      ack_last <= code;
    end
    // accepts counted apart so a stray accept pulse shows too
    if (acc === 1'b1) begin
      n_acc <= n_acc + 1;
    end
  end
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("FAIL %s exp %h got %h", n, e, g);
    end
  endtask
  task wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task rreg(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk($sformatf("reg %h", a), e, rdata);
  endtask
  task pk(input logic r, input logic [3:0] e);
    k = n_ack;
    j = n_acc;
    node.pkt(r);
    chk("ack_count", k + 1, n_ack);
    chk("ack_code", {28'h0, e}, {28'h0, ack_last});
    chk("accept_count", j + ((e == 4'h1 || e == 4'h2) ? 1 : 0), n_acc);
  endtask
  task print_verdict;
    if (n_errors == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // watchdog: whole run needs well under 1000 cycles
  initial begin
    #100us;
    n_errors++;
    print_verdict;
  end
  // register table, then packets, rom gating, resets
  initial begin
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    for (int i = 0; i < 12; i++)
      if (rows[i][40]) wreg(rows[i][39:32], rows[i][31:0]);
      else rreg(rows[i][39:32], rows[i][31:0]);
    k = n_ack;
    j = n_acc;
    node.pkt(1'b0);
    chk("ack_count", k, n_ack);
    chk("accept_count", j, n_acc);
    wreg(8'h50, 32'h0002_0000);
    pk(1'b0, 4'hB);
    chk("irq", 1, irq);
    rreg(8'h80, 32'h0800_0000);
    wreg(8'h80, 32'h0800_0000);
    node.evt(1'b1);
    rreg(8'h80, 32'h0008_0000);
    wreg(8'h80, 32'h0008_0000);
    rreg(8'h80, 32'h0000_0000);
    chk("irq", 0, irq);
    wreg(8'h54, 32'h2000_0000);
    pk(1'b1, 4'h1);
    pk(1'b0, 4'h2);
    wreg(8'h54, 32'h8000_0000);
    pk(1'b1, 4'hE);
    wreg(8'hA0, 32'h1234_5400);
    node.evt(1'b0);
    rreg(8'h34, 32'h0000_0000);
    wreg(8'h54, 32'h0002_0000);
    wreg(8'h50, 32'h8000_0000);
    wreg(8'h50, 32'h0002_0000);
    node.evt(1'b0);
    rreg(8'h34, 32'h1234_5400);
    chk("romu", 1, romu);
    @(posedge clk);
    fetch <= 1'b1;
    @(posedge clk);
    fetch <= 1'b0;
    rreg(8'h50, 32'h0082_0000);
    chk("romu", 0, romu);
    wreg(8'h50, 32'h4000_0000);
    rreg(8'h54, 32'h4082_0000);
    chk("swap", 0, swap);
    wreg(8'h50, 32'h0001_0000);
    repeat (10) @(posedge clk);
    rreg(8'h50, 32'h0080_0000);
    chk("link", 0, link);
    // hardware reset in mid-run must drop a set image valid flag
    wreg(8'h50, 32'h8000_0000);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    rreg(8'h50, 32'h0080_0000);
    chk("romu", 0, romu);
    print_verdict;
  end
endmodule
